// >>> common/oag_defs.svh
// constants for the operand address generation block
// Contract
// - program, data, register spaces kept separate
// - never write program memory
// - fetch on/off chip chosen by address
// - working registers in four banks, low 32 bytes
// - register-only instruction takes one cycle
// - direct address above 7Fh is special register
// - low bit addresses map onto bytes 20h-2Fh
// - special register bits only at x0/x8
// - indirect through pointer zero or one
// - stack accesses address RAM through stack pointer
// - pointer byte low, port latch high
// - selected data pointer gives full address
// - table read at accumulator plus base
// - relative branch only when condition holds
// - displacement added to next instruction address
// - page target joins top five bits, field
// - immediate operand taken from instruction bytes
`ifndef OAG_DEFS_SVH
`define OAG_DEFS_SVH
`define OAG_PSW_ADDR      8'hD0
`define OAG_SP_ADDR       8'h81
`define OAG_PSW_RESET     8'h00
`define OAG_SP_RESET      8'h07
`define OAG_PSW_RS_LSB    3
`define OAG_DIRECT_TOP    8'h7F
`define OAG_BIT_RAM_BASE  8'h20
`define OAG_ONCHIP_TOP    16'h3FFF
`define OAG_PAGE_BITS     11
`endif

// >>> common/oag_pkg.sv
// types for the operand address generation block
package oag_pkg;
   typedef enum logic [3:0] {
      OAG_MODE_REG      = 4'h0,
      OAG_MODE_DIRECT   = 4'h1,
      OAG_MODE_BIT      = 4'h2,
      OAG_MODE_INDIRECT = 4'h3,
      OAG_MODE_STACK    = 4'h4,
      OAG_MODE_XDATA_RI = 4'h5,
      OAG_MODE_XDATA_DP = 4'h6,
      OAG_MODE_IMM      = 4'h7,
      OAG_MODE_TABLE    = 4'h8,
      OAG_MODE_REL      = 4'h9,
      OAG_MODE_PAGE     = 4'hA,
      OAG_MODE_NONE     = 4'hF
   } oag_mode_t;
   typedef enum logic [1:0] {
      OAG_SPACE_REG  = 2'h0,
      OAG_SPACE_CODE = 2'h1,
      OAG_SPACE_DATA = 2'h2,
      OAG_SPACE_NONE = 2'h3
   } oag_space_t;
endpackage

// >>> logic/oag_bit_map.sv
// maps a bit address to its byte address and bit position
`timescale 1ns/1ps
`include "oag_defs.svh"
module oag_bit_map
   import oag_pkg::*;
(
   input  wire logic [7:0] bit_addr_i,
   output logic      [7:0] byte_addr_o,
   output logic      [2:0] bit_pos_o
);
   // low half lands in RAM 20h-2Fh, high half on x0/x8 special registers
   always_comb begin
      bit_pos_o = bit_addr_i[2:0];
      if (bit_addr_i[7] == 1'b0) begin
         byte_addr_o = `OAG_BIT_RAM_BASE + {4'h0, bit_addr_i[6:3]};
      end else begin
         byte_addr_o = {bit_addr_i[7:3], 3'h0};
      end
   end
endmodule

// >>> logic/oag_top.sv
// operand and branch target address generation for the core
`timescale 1ns/1ps
`include "oag_defs.svh"
module oag_top
   import oag_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        req_i,
   input  wire oag_mode_t   mode_i,
   input  wire logic [7:0]  operand_i,
   input  wire logic [10:0] page_field_i,
   input  wire logic [2:0]  reg_num_i,
   input  wire logic        ptr_sel_i,
   input  wire logic        stack_pop_i,
   input  wire logic        table_base_dp_i,
   input  wire logic        cond_i,
   input  wire logic        write_i,
   input  wire logic [15:0] next_pc_i,
   input  wire logic [7:0]  accumulator_i,
   input  wire logic [7:0]  indirect_pointer_zero_i,
   input  wire logic [7:0]  indirect_pointer_one_i,
   input  wire logic [7:0]  high_address_port_latch_i,
   input  wire logic [15:0] data_pointer_zero_i,
   input  wire logic [15:0] data_pointer_one_i,
   input  wire logic        dptr_sel_i,
   input  wire logic [15:0] fetch_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic             valid_o,
   output oag_space_t       space_o,
   output logic             sfr_sel_o,
   output logic [15:0]      addr_o,
   output logic [2:0]       bit_pos_o,
   output logic             bit_op_o,
   output logic             wr_o,
   output logic [7:0]       imm_o,
   output logic             imm_valid_o,
   output logic             branch_o,
   output logic [15:0]      target_o,
   output logic             single_cycle_o,
   output logic             fetch_onchip_o,
   output logic [7:0]       processor_status_word_o,
   output logic [7:0]       stack_pointer_o
);
   logic       rst_sync_a;
   logic       rst_sync_b;
   logic [7:0] processor_status_word;
   logic [7:0] stack_pointer;
   logic [7:0] bit_byte;
   logic [2:0] bit_pos;
   logic [7:0] reg_addr;
   logic [7:0] ind_ptr;
   logic [7:0] stack_addr;
   logic [15:0] dptr;
   logic [15:0] rel_target;
   logic [15:0] page_target;
   oag_space_t  next_space;
   logic [15:0] next_addr;
   logic        next_sfr;
   logic        next_branch;
   logic [15:0] next_target;

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_a <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_sync_a <= 1'b1;
         rst_sync_b <= rst_sync_a;
      end
   end

   // status word write from the special register path
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         processor_status_word <= `OAG_PSW_RESET;
      end else if (sfr_wr_i && sfr_addr_i == `OAG_PSW_ADDR) begin
         processor_status_word <= sfr_wdata_i;
      end
   end

   // stack pointer: pre-increment on push, post-decrement on pop
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         stack_pointer <= `OAG_SP_RESET;
      end else if (sfr_wr_i && sfr_addr_i == `OAG_SP_ADDR) begin
         stack_pointer <= sfr_wdata_i;
      end else if (req_i && mode_i == OAG_MODE_STACK) begin
         stack_pointer <= stack_pop_i ? stack_pointer - 8'h01 : stack_pointer + 8'h01;
      end
   end

   oag_bit_map oag_bit_map_inst (
      .bit_addr_i  (operand_i),
      .byte_addr_o (bit_byte),
      .bit_pos_o   (bit_pos)
   );

   // address pieces per mode
   assign reg_addr = {3'h0, processor_status_word[`OAG_PSW_RS_LSB +: 2], reg_num_i};
   assign ind_ptr = ptr_sel_i ? indirect_pointer_one_i : indirect_pointer_zero_i;
   // push writes at pointer plus one, pop reads at pointer
   assign stack_addr = stack_pop_i ? stack_pointer : stack_pointer + 8'h01;
   assign dptr = dptr_sel_i ? data_pointer_one_i : data_pointer_zero_i;
   // next_pc_i already points past the branch, so no extra offset here
   assign rel_target = next_pc_i + {{8{operand_i[7]}}, operand_i};
   assign page_target = {next_pc_i[15:`OAG_PAGE_BITS], page_field_i};

   // mode decode into space, address and branch target
   always_comb begin
      next_space  = OAG_SPACE_NONE;
      next_addr   = 16'h0000;
      next_sfr    = 1'b0;
      next_branch = 1'b0;
      next_target = next_pc_i;
      case (mode_i)
         OAG_MODE_REG: begin
            next_space = OAG_SPACE_REG;
            next_addr  = {8'h00, reg_addr};
         end
         OAG_MODE_DIRECT: begin
            next_space = OAG_SPACE_REG;
            next_addr  = {8'h00, operand_i};
            next_sfr   = operand_i > `OAG_DIRECT_TOP;
         end
         OAG_MODE_BIT: begin
            next_space = OAG_SPACE_REG;
            next_addr  = {8'h00, bit_byte};
            next_sfr   = operand_i[7];
         end
         OAG_MODE_INDIRECT: begin
            next_space = OAG_SPACE_REG;
            next_addr  = {8'h00, ind_ptr};
         end
         OAG_MODE_STACK: begin
            next_space = OAG_SPACE_REG;
            next_addr  = {8'h00, stack_addr};
         end
         OAG_MODE_XDATA_RI: begin
            next_space = OAG_SPACE_DATA;
            next_addr  = {high_address_port_latch_i, ind_ptr};
         end
         OAG_MODE_XDATA_DP: begin
            next_space = OAG_SPACE_DATA;
            next_addr  = dptr;
         end
         OAG_MODE_TABLE: begin
            next_space = OAG_SPACE_CODE;
            next_addr  = (table_base_dp_i ? dptr : next_pc_i) + {8'h00, accumulator_i};
         end
         OAG_MODE_REL: begin
            next_branch = cond_i;
            next_target = cond_i ? rel_target : next_pc_i;
         end
         OAG_MODE_PAGE: begin
            next_branch = 1'b1;
            next_target = page_target;
         end
         default: begin
            next_space = OAG_SPACE_NONE;
         end
      endcase
   end

   // registered outputs
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         valid_o        <= 1'b0;
         space_o        <= OAG_SPACE_NONE;
         sfr_sel_o      <= 1'b0;
         addr_o         <= 16'h0000;
         bit_pos_o      <= 3'h0;
         bit_op_o       <= 1'b0;
         wr_o           <= 1'b0;
         imm_o          <= 8'h00;
         imm_valid_o    <= 1'b0;
         branch_o       <= 1'b0;
         target_o       <= 16'h0000;
         single_cycle_o <= 1'b0;
      end else begin
         valid_o        <= req_i;
         space_o        <= req_i ? next_space : OAG_SPACE_NONE;
         sfr_sel_o      <= req_i & next_sfr;
         addr_o         <= next_addr;
         bit_pos_o      <= bit_pos;
         bit_op_o       <= req_i && mode_i == OAG_MODE_BIT;
         // code space is never written
         wr_o           <= req_i & write_i & (next_space != OAG_SPACE_CODE);
         imm_o          <= operand_i;
         imm_valid_o    <= req_i && mode_i == OAG_MODE_IMM;
         branch_o       <= req_i & next_branch;
         target_o       <= next_target;
         single_cycle_o <= req_i && mode_i == OAG_MODE_REG;
      end
   end

   // fetch steering purely by address; on-chip size is fixed here
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         fetch_onchip_o <= 1'b1;
      end else begin
         fetch_onchip_o <= fetch_addr_i <= `OAG_ONCHIP_TOP;
      end
   end

   // mirror of the two special registers this block owns
   always_ff @(posedge clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         processor_status_word_o <= `OAG_PSW_RESET;
         stack_pointer_o         <= `OAG_SP_RESET;
      end else begin
         processor_status_word_o <= processor_status_word;
         stack_pointer_o         <= stack_pointer;
      end
   end

   property p_no_code_write;
      @(posedge clk_i) disable iff (!rst_sync_b)
      space_o == OAG_SPACE_CODE |-> !wr_o;
   endproperty
   a_no_code_write: assert property (p_no_code_write) else $error("code write");

   property p_reg_bank;
      @(posedge clk_i) disable iff (!rst_sync_b)
      req_i && mode_i == OAG_MODE_REG |=> addr_o[7:0] ==
         {3'h0, $past(processor_status_word[4:3]), $past(reg_num_i)};
   endproperty
   a_reg_bank: assert property (p_reg_bank) else $error("bank address");

   property p_single;
      @(posedge clk_i) disable iff (!rst_sync_b)
      req_i && mode_i == OAG_MODE_REG |=> single_cycle_o && valid_o;
   endproperty
   a_single: assert property (p_single) else $error("single cycle");

   property p_direct_sfr;
      @(posedge clk_i) disable iff (!rst_sync_b)
      req_i && mode_i == OAG_MODE_DIRECT |=> sfr_sel_o == addr_o[7];
   endproperty
   a_direct_sfr: assert property (p_direct_sfr) else $error("direct split");

   property p_bit_ram;
      @(posedge clk_i) disable iff (!rst_sync_b)
      req_i && mode_i == OAG_MODE_BIT && !operand_i[7] |=>
         addr_o[7:4] == 4'h2 && !sfr_sel_o;
   endproperty
   a_bit_ram: assert property (p_bit_ram) else $error("bit ram");

   property p_bit_sfr;
      @(posedge clk_i) disable iff (!rst_sync_b)
      bit_op_o && sfr_sel_o |-> addr_o[2:0] == 3'h0;
   endproperty
   a_bit_sfr: assert property (p_bit_sfr) else $error("bit sfr");

   property p_xdata_ri;
      @(posedge clk_i) disable iff (!rst_sync_b)
      req_i && mode_i == OAG_MODE_XDATA_RI |=>
         addr_o[15:8] == $past(high_address_port_latch_i) && space_o == OAG_SPACE_DATA;
   endproperty
   a_xdata_ri: assert property (p_xdata_ri) else $error("xdata page");

   property p_rel;
      @(posedge clk_i) disable iff (!rst_sync_b)
      req_i && mode_i == OAG_MODE_REL && !cond_i |=> !branch_o && target_o == $past(next_pc_i);
   endproperty
   a_rel: assert property (p_rel) else $error("relative");

   property p_page;
      @(posedge clk_i) disable iff (!rst_sync_b)
      req_i && mode_i == OAG_MODE_PAGE |=> target_o[15:11] == $past(next_pc_i[15:11]);
   endproperty
   a_page: assert property (p_page) else $error("page block");

   property p_table;
      @(posedge clk_i) disable iff (!rst_sync_b)
      req_i && mode_i == OAG_MODE_TABLE |=> space_o == OAG_SPACE_CODE && addr_o ==
         ($past(table_base_dp_i) ? $past(dptr) : $past(next_pc_i)) +
         {8'h00, $past(accumulator_i)};
   endproperty
   a_table: assert property (p_table) else $error("table read");

   c_branch: cover property (@(posedge clk_i) disable iff (!rst_sync_b) branch_o);
   c_table: cover property (@(posedge clk_i) disable iff (!rst_sync_b)
      space_o == OAG_SPACE_CODE);
   c_xdata: cover property (@(posedge clk_i) disable iff (!rst_sync_b)
      space_o == OAG_SPACE_DATA && wr_o);
   c_bit_sfr: cover property (@(posedge clk_i) disable iff (!rst_sync_b)
      bit_op_o && sfr_sel_o);
endmodule

// >>> tb/oag_ext_mem.sv
// model of external program and data memory behind the multiplexed ports
`timescale 1ns/1ps
module oag_ext_mem
   import oag_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        valid_i,
   input  wire oag_space_t  space_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        wr_i,
   output logic [7:0]       rdata_o,
   output logic [7:0]       code_wr_o
);
   logic [7:0] mem [256];
   initial begin
      code_wr_o = 8'h00;
      rdata_o = 8'h00;
   end
   // program memory has no write path, so any attempt is only counted
   always @(posedge clk_i) begin
      if (valid_i && space_i == OAG_SPACE_DATA && wr_i) mem[addr_i[7:0]] <= addr_i[15:8];
      if (valid_i && space_i == OAG_SPACE_CODE && wr_i) code_wr_o <= code_wr_o + 8'h01;
      // idle bus inverts its previous value each cycle, so every second idle cycle repeats the last byte
      rdata_o <= (valid_i && space_i != OAG_SPACE_REG) ? mem[addr_i[7:0]] : ~rdata_o;
   end
endmodule

// >>> tb/operand_address_generation_test.sv
// self-checking bench for the operand address generation block
`timescale 1ns/1ps
module operand_address_generation_test
   import oag_pkg::*;
;
   // masks over {sc, imm_valid, imm, space, sfr, addr, bit_pos, bit_op, wr, branch, target}
   localparam logic [50:0] M_REG = 51'h1FFFFC60000;
   localparam logic [50:0] M_BIT = 51'h1FFFFFE0000;
   localparam logic [50:0] M_DAT = 51'h1BFFFC20000;
   localparam logic [50:0] M_BR  = 51'h1FFFF;
   localparam logic [50:0] M_IMM = 51'h3FE0000000000;
   localparam logic [50:0] M_SC  = 51'h4000000000000;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, req_i = 1'b0, ptr_sel_i = 1'b0, stack_pop_i = 1'b0;
   logic        table_base_dp_i = 1'b0, cond_i = 1'b0, write_i = 1'b0, dptr_sel_i = 1'b0;
   logic        sfr_wr_i = 1'b0;
   oag_mode_t   mode_i = OAG_MODE_NONE;
   logic [7:0]  operand_i = 8'h00, accumulator_i = 8'h00, indirect_pointer_zero_i = 8'h9A;
   logic [7:0]  indirect_pointer_one_i = 8'hC3, high_address_port_latch_i = 8'h5A;
   logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
   logic [10:0] page_field_i = 11'h000;
   logic [2:0]  reg_num_i = 3'h0;
   logic [15:0] next_pc_i = 16'h0000, data_pointer_zero_i = 16'h1234;
   logic [15:0] data_pointer_one_i = 16'hBEEF, fetch_addr_i = 16'h0000;
   logic [15:0] e_pc;
   logic        valid_o, sfr_sel_o, bit_op_o, wr_o, imm_valid_o, branch_o, single_cycle_o;
   logic        fetch_onchip_o;
   oag_space_t  space_o;
   logic [15:0] addr_o, target_o;
   logic [7:0]  imm_o, processor_status_word_o, stack_pointer_o, rdata, code_wr, v, e_sp;
   logic [2:0]  bit_pos_o;
   logic [50:0] q_exp[$], q_msk[$];
   int          mismatches = 0, comparisons = 0, cycles = 0, i, k;
   logic [15:0] bit_tab [4] = '{16'h0020, 16'h7F2F, 16'hB7B0, 16'h0821};

   oag_top oag_top_inst (.clk_i, .rst_n_i, .req_i, .mode_i, .operand_i, .page_field_i, .reg_num_i,
      .ptr_sel_i, .stack_pop_i, .table_base_dp_i, .cond_i, .write_i, .next_pc_i, .accumulator_i,
      .indirect_pointer_zero_i, .indirect_pointer_one_i, .high_address_port_latch_i,
      .data_pointer_zero_i, .data_pointer_one_i, .dptr_sel_i, .fetch_addr_i, .sfr_wr_i,
      .sfr_addr_i, .sfr_wdata_i, .valid_o, .space_o, .sfr_sel_o, .addr_o, .bit_pos_o, .bit_op_o,
      .wr_o, .imm_o, .imm_valid_o, .branch_o, .target_o, .single_cycle_o, .fetch_onchip_o,
      .processor_status_word_o, .stack_pointer_o);
   oag_ext_mem oag_ext_mem_inst (.clk_i, .valid_i(valid_o), .space_i(space_o), .addr_i(addr_o),
      .wr_i(wr_o), .rdata_o(rdata), .code_wr_o(code_wr));

   always #2.5 clk_i = ~clk_i;

   function automatic logic [50:0] ev(logic [1:0] sp, logic sf, logic [15:0] a, logic [2:0] bp,
      logic bo, logic w, logic br, logic [15:0] t, logic [7:0] im, logic sc);
      return {sc, 1'b1, im, sp, sf, a, bp, bo, w, br, t};
   endfunction
   task automatic chk(logic [50:0] got, logic [50:0] exp, logic [50:0] msk);
      comparisons++;
      if ((got & msk) !== (exp & msk)) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
      end
   endtask
   task automatic chk8(logic [7:0] got, logic [7:0] exp);
      chk({43'h0, got}, {43'h0, exp}, 51'hFF);
   endtask
   task automatic wrap_up();
      $display("counts: comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one request per cycle, back to back allowed; the answer is queued as it is issued
   task automatic req(oag_mode_t m, logic [50:0] exp, logic [50:0] msk);
      req_i <= 1'b1;
      mode_i <= m;
      q_exp.push_back(exp);
      q_msk.push_back(msk);
      @(posedge clk_i);
   endtask
   task automatic idle(int n);
      req_i <= 1'b0;
      sfr_wr_i <= 1'b0;
      repeat (n) @(posedge clk_i);
   endtask
   // no request may ride along with a special register write, it would go unnoted
   task automatic sfrw(logic [7:0] a, logic [7:0] d);
      req_i <= 1'b0;
      sfr_wr_i <= 1'b1;
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      @(posedge clk_i);
      idle(3);
   endtask
   task automatic fin(string s);
      idle(3);
      $display("test %s done", s);
   endtask

   // result watcher: every valid answer must match the oldest queued note
   always @(negedge clk_i) begin
      if (valid_o === 1'b1) begin
         if (q_exp.size() == 0) begin
            chk8(8'h00, 8'h01);
         end else begin
            chk({single_cycle_o, imm_valid_o, imm_o, space_o, sfr_sel_o, addr_o, bit_pos_o, bit_op_o,
               wr_o, branch_o, target_o}, q_exp.pop_front(), q_msk.pop_front());
         end
      end
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         wrap_up();
      end
   end

   initial begin
      v = 8'($urandom(82));
      e_sp = 8'h07;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      idle(4);
      chk8(processor_status_word_o, 8'h00);
      chk8(stack_pointer_o, e_sp);
      for (i = 0; i < 4; i++) begin
         fetch_addr_i <= (i[0]) ? 16'h3FFF + 16'(i[1]) : {16{i[1]}};
         idle(3);
         chk8({7'h0, fetch_onchip_o}, {7'h0, ~i[1]});
      end
      fin("fetch");
      for (k = 0; k < 4; k++) begin
         sfrw(8'hD0, {3'h0, k[1:0], 3'h0});
         chk8(processor_status_word_o, {3'h0, k[1:0], 3'h0});
         for (i = 0; i < 2; i++) begin
            v = (i == 1) ? 8'h07 : 8'($urandom);
            reg_num_i <= v[2:0];
            req(OAG_MODE_REG, ev(OAG_SPACE_REG, '0, {11'h0, k[1:0], v[2:0]}, '0, '0, '0, '0, '0, '0,
               '1), M_REG | M_SC);
         end
      end
      fin("register");
      for (i = 0; i < 8; i++) begin
         v = (i < 2) ? 8'h7F + 8'(i) : 8'($urandom);
         operand_i <= v;
         req(OAG_MODE_DIRECT, ev(OAG_SPACE_REG, v > 8'h7F, {8'h00, v}, '0, '0, '0, '0, '0, '0, '0),
            M_REG);
      end
      for (i = 0; i < 5; i++) begin
         v = (i < 4) ? bit_tab[i][15:8] : 8'($urandom) & 8'h7F;
         operand_i <= v;
         req(OAG_MODE_BIT, ev(OAG_SPACE_REG, v[7],
            {8'h00, (i < 4) ? bit_tab[i][7:0] : 8'h20 + (v >> 3)},
            v[2:0], '1, '0, '0, '0, '0, '0), M_BIT);
      end
      for (i = 0; i < 2; i++) begin
         ptr_sel_i <= i[0];
         req(OAG_MODE_INDIRECT, ev(OAG_SPACE_REG, '0, {8'h00, i[0] ? 8'hC3 : 8'h9A}, '0, '0, '0, '0,
            '0, '0, '0), M_REG);
      end
      fin("direct");
      for (i = 0; i < 4; i++) begin
         if (i == 3) sfrw(8'h81, 8'hFF);
         if (i == 3) e_sp = 8'hFF;
         stack_pop_i <= (i == 2);
         req(OAG_MODE_STACK, ev(OAG_SPACE_REG, '0, {8'h00, (i == 2) ? e_sp : e_sp + 8'h01}, '0, '0,
            '0, '0, '0, '0, '0), M_REG);
         e_sp = (i == 2) ? e_sp - 8'h01 : e_sp + 8'h01;
         idle(3);
         chk8(stack_pointer_o, e_sp);
      end
      fin("stack");
      for (i = 0; i < 2; i++) begin
         write_i <= 1'b1;
         ptr_sel_i <= i[0];
         dptr_sel_i <= i[0];
         req(OAG_MODE_XDATA_RI, ev(OAG_SPACE_DATA, '0, {8'h5A, i[0] ? 8'hC3 : 8'h9A}, '0, '0, '1, '0,
            '0, '0, '0), M_DAT);
         req(OAG_MODE_XDATA_DP, ev(OAG_SPACE_DATA, '0, i[0] ? 16'hBEEF : 16'h1234, '0, '0, '1, '0,
            '0, '0, '0), M_DAT);
         accumulator_i <= 8'hF0;
         next_pc_i <= 16'hFFF0 + 16'(i);
         table_base_dp_i <= i[0];
         req(OAG_MODE_TABLE, ev(OAG_SPACE_CODE, '0, i[0] ? 16'hBFDF : 16'hFFF0 + 16'h00F0,
            '0, '0, '0, '0, '0, '0, '0), M_DAT);
      end
      write_i <= 1'b0;
      dptr_sel_i <= 1'b0;
      // read back what the first data pointer write left in the far memory
      req(OAG_MODE_XDATA_DP, ev(OAG_SPACE_DATA, '0, 16'h1234, '0, '0, '0, '0, '0, '0, '0),
         M_DAT);
      idle(1);
      @(negedge clk_i);
      chk8(rdata, 8'h12);
      fin("external");
      for (i = 0; i < 4; i++) begin
         v = 8'($urandom);
         e_pc = (i == 0) ? 16'h1000 : 16'h0872 + {v, 8'h00};
         operand_i <= v;
         page_field_i <= {3'h1, v};
         cond_i <= (i != 1);
         next_pc_i <= e_pc;
         // a branch not taken must leave the target on the next instruction
         req(OAG_MODE_REL, ev('0, '0, '0, '0, '0, '0, (i != 1), e_pc + ((i != 1) ?
            {{8{v[7]}}, v} : 16'h0000), '0, '0), M_BR);
         req(OAG_MODE_PAGE, ev('0, '0, '0, '0, '0, '0, '1, {e_pc[15:11], 3'h1, v}, '0, '0),
            M_BR);
         req(OAG_MODE_IMM, ev('0, '0, '0, '0, '0, '0, '0, '0, v, '0), M_IMM);
      end
      fin("branch");
      chk8(code_wr, 8'h00);
      chk8(8'(q_exp.size()), 8'h00);
      wrap_up();
   end
endmodule
